// ---- core/lpc_defines.svh ----
// Shared widths, reset values and link timing for the pin capture lanes
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

`define LPC_CA_W          10
`define LPC_DQW           32
`define LPC_BYTE_W        8
`define LPC_CLK_PERIOD_NS 20
`define LPC_CK_PERIOD_NS  160
`define LPC_CK_HALF       ((`LPC_CK_PERIOD_NS / `LPC_CLK_PERIOD_NS) / 2)
`define LPC_CKE_RST       1'b0
`define LPC_CSN_RST       1'b1
`define LPC_DQS_T_IDLE    1'b0
`define LPC_DQS_C_IDLE    1'b1

`endif

// ---- core/lpc_pkg.sv ----
// Types shared by both ends of the pin capture lanes
package lpc_pkg;
`include "lpc_defines.svh"

    typedef struct packed {
        logic                 ckePrev;
        logic                 ckeNow;
        logic                 csN;
        logic [`LPC_CA_W-1:0] caRise;
        logic [`LPC_CA_W-1:0] caFall;
    } lpc_cmd_s;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_WAIT,
        RD_BEAT0,
        RD_BEAT1
    } lpc_rd_e;

    typedef enum logic [2:0] {
        WR_IDLE,
        WR_B0,
        WR_B0S,
        WR_B1,
        WR_B1S
    } lpc_wr_e;
endpackage

// ---- core/lpc_link_if.sv ----
// Pin bundle between memory device and host controller
`timescale 1ns/1ps
`include "lpc_defines.svh"
interface lpc_link_if #(
    parameter int DQW = `LPC_DQW
);
    localparam int LN = DQW / `LPC_BYTE_W;

    logic                 ckT;
    logic                 ckC;
    logic                 cke;
    logic                 csN;
    logic [`LPC_CA_W-1:0] ca;
    logic [LN-1:0]        dm;
    logic [DQW-1:0]       hostDq;
    logic [LN-1:0]        hostDqsT;
    logic [LN-1:0]        hostDqsC;
    logic [LN-1:0]        hostOe;
    logic [DQW-1:0]       devDq;
    logic [LN-1:0]        devDqsT;
    logic [LN-1:0]        devDqsC;
    logic [LN-1:0]        devOe;
    logic [DQW-1:0]       dq;
    logic [LN-1:0]        dqsT;
    logic [LN-1:0]        dqsC;

    // Wire level per lane; an undriven strobe rests in its low state
    genvar l;
    for (l = 0; l < LN; l++) begin : g_lane
        assign dq[l*8 +: 8] = devOe[l]  ? devDq[l*8 +: 8] :
                              hostOe[l] ? hostDq[l*8 +: 8] : 8'h00;
        assign dqsT[l] = devOe[l] ? devDqsT[l] :
                         hostOe[l] ? hostDqsT[l] : `LPC_DQS_T_IDLE;
        assign dqsC[l] = devOe[l] ? devDqsC[l] :
                         hostOe[l] ? hostDqsC[l] : `LPC_DQS_C_IDLE;
    end

    modport device (
        input  ckT, ckC, cke, csN, ca, dm, dq, dqsT, dqsC,
        output devDq, devDqsT, devDqsC, devOe
    );
    modport host (
        output ckT, ckC, cke, csN, ca, dm, hostDq, hostDqsT, hostDqsC,
        output hostOe,
        input  dq, dqsT, dqsC
    );
endinterface

// ---- core/lpc_host.sv ----
// Host controller end: link clock divider, command, write and read lanes
`timescale 1ns/1ps
`include "lpc_defines.svh"
module lpc_host
    import lpc_pkg::*;
#(
    parameter int DQW     = `LPC_DQW,
    parameter int CK_HALF = `LPC_CK_HALF
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    lpc_link_if.host                  link,
    input  wire logic                 cmdValid,
    output logic                      cmdReady,
    input  wire logic                 cmdCke,
    input  wire logic                 cmdCsN,
    input  wire logic [`LPC_CA_W-1:0] cmdCaRise,
    input  wire logic [`LPC_CA_W-1:0] cmdCaFall,
    input  wire logic                 wrValid,
    output logic                      wrReady,
    input  wire logic [2*DQW-1:0]     wrData,
    input  wire logic [2*DQW/8-1:0]   wrMask,
    output logic [DQW/8-1:0]          rdStb,
    output logic [DQW/8-1:0]          rdRise,
    output logic [DQW-1:0]            rdData
);
    localparam int LN  = DQW / `LPC_BYTE_W;
    localparam int CW  = $clog2(CK_HALF + 1);
    localparam int MID = CK_HALF / 2;

    if ((DQW != 16 && DQW != 32) || CK_HALF < 2) begin : g_chk
        $error("lpc_host: DQW must be 16 or 32 and CK_HALF at least 2");
    end

    logic [CW-1:0]        cnt_r, cnt_nxt;
    logic                 ckT_r, ckT_nxt;
    logic                 cke_r, cke_nxt;
    logic                 csN_r, csN_nxt;
    logic [`LPC_CA_W-1:0] ca_r, ca_nxt, caFall_r, caFall_nxt;
    logic [`LPC_CA_W-1:0] caRise_r, caRise_nxt;
    logic                 cmdReady_r, cmdReady_nxt;
    lpc_wr_e              wrSt_r, wrSt_nxt;
    logic                 wrReady_r, wrReady_nxt;
    logic [DQW-1:0]       dq_r, dq_nxt, beat1_r, beat1_nxt;
    logic [LN-1:0]        dm_r, dm_nxt, mask1_r, mask1_nxt;
    logic                 dqsT_r, dqsT_nxt;
    logic                 oe_r, oe_nxt;
    logic                 tick, negTick, posTick, midTick, wrTake;

    always_comb begin
        tick    = (cnt_r == CW'(CK_HALF - 1));
        negTick = tick && ckT_r;
        posTick = tick && !ckT_r;
        midTick = (cnt_r == CW'(MID - 1));
        cnt_nxt = tick ? '0 : CW'(cnt_r + 1'b1);
        ckT_nxt = tick ? !ckT_r : ckT_r;
        // Ready sits on the cycle that will take the next falling edge
        cmdReady_nxt = (cnt_nxt == CW'(CK_HALF - 1)) && ckT_nxt;
        cke_nxt    = cke_r;
        csN_nxt    = csN_r;
        ca_nxt     = ca_r;
        caRise_nxt = caRise_r;
        caFall_nxt = caFall_r;
        if (negTick) begin
            if (cmdValid && cmdReady_r) begin
                cke_nxt    = cmdCke;
                csN_nxt    = cmdCsN;
                caRise_nxt = cmdCaRise;
                caFall_nxt = cmdCaFall;
            end else begin
                csN_nxt    = `LPC_CSN_RST;
                caRise_nxt = '0;
                caFall_nxt = '0;
            end
        end
        // A half changes mid-half: the far end samples pins and clock
        // together, so a change on the edge itself would be misread
        if (midTick) begin
            ca_nxt = ckT_r ? caFall_r : caRise_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r      <= '0;
            ckT_r      <= 1'b0;
            cke_r      <= `LPC_CKE_RST;
            csN_r      <= `LPC_CSN_RST;
            ca_r       <= '0;
            caFall_r   <= '0;
            caRise_r   <= '0;
            cmdReady_r <= 1'b0;
        end else if (ce) begin
            cnt_r      <= cnt_nxt;
            ckT_r      <= ckT_nxt;
            cke_r      <= cke_nxt;
            csN_r      <= csN_nxt;
            ca_r       <= ca_nxt;
            caFall_r   <= caFall_nxt;
            caRise_r   <= caRise_nxt;
            cmdReady_r <= cmdReady_nxt;
        end
    end

    // Write lanes: data moves on link edges, strobe toggles mid-half
    always_comb begin
        wrTake    = wrValid && wrReady_r;
        wrSt_nxt  = wrSt_r;
        dq_nxt    = dq_r;
        beat1_nxt = beat1_r;
        dm_nxt    = dm_r;
        mask1_nxt = mask1_r;
        dqsT_nxt  = dqsT_r;
        oe_nxt    = oe_r;
        unique case (wrSt_r)
            WR_IDLE, WR_B1S: begin
                if (negTick && wrTake) begin
                    dq_nxt    = wrData[DQW-1:0];
                    beat1_nxt = wrData[2*DQW-1:DQW];
                    dm_nxt    = wrMask[LN-1:0];
                    mask1_nxt = wrMask[2*LN-1:LN];
                    dqsT_nxt  = 1'b0;
                    oe_nxt    = 1'b1;
                    wrSt_nxt  = WR_B0;
                end else if (negTick) begin
                    oe_nxt   = 1'b0;
                    dm_nxt   = '0;
                    wrSt_nxt = WR_IDLE;
                end
            end
            WR_B0: if (midTick) begin
                dqsT_nxt = 1'b1;
                wrSt_nxt = WR_B0S;
            end
            WR_B0S: if (posTick) begin
                dq_nxt   = beat1_r;
                dm_nxt   = mask1_r;
                wrSt_nxt = WR_B1;
            end
            WR_B1: if (midTick) begin
                dqsT_nxt = 1'b0;
                wrSt_nxt = WR_B1S;
            end
        endcase
        wrReady_nxt = cmdReady_nxt &&
                      (wrSt_nxt == WR_IDLE || wrSt_nxt == WR_B1S);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrSt_r    <= WR_IDLE;
            wrReady_r <= 1'b0;
            dq_r      <= '0;
            beat1_r   <= '0;
            dm_r      <= '0;
            mask1_r   <= '0;
            dqsT_r    <= `LPC_DQS_T_IDLE;
            oe_r      <= 1'b0;
        end else if (ce) begin
            wrSt_r    <= wrSt_nxt;
            wrReady_r <= wrReady_nxt;
            dq_r      <= dq_nxt;
            beat1_r   <= beat1_nxt;
            dm_r      <= dm_nxt;
            mask1_r   <= mask1_nxt;
            dqsT_r    <= dqsT_nxt;
            oe_r      <= oe_nxt;
        end
    end

    // Read capture: strobe and data share one synchroniser depth
    logic [DQW+2*LN-1:0] rs1_r, rs2_r;
    logic [DQW-1:0]      dqS;
    logic [LN-1:0]       dqsTS, dqsCS;
    logic [LN-1:0]       hi_r, hi_nxt, stb_r, stb_nxt, rise_r, rise_nxt;
    logic [DQW-1:0]      byte_r, byte_nxt;
    logic [1:0]          oeHist_r;
    logic                ownDrv;

    assign {dqS, dqsTS, dqsCS} = rs2_r;

    // Own strobe edges still sit in the synchroniser after oe drops
    assign ownDrv = oe_r || (oeHist_r != 2'b00);

    genvar l;
    for (l = 0; l < LN; l++) begin : g_rd
        always_comb begin
            hi_nxt[l]         = hi_r[l];
            stb_nxt[l]        = 1'b0;
            rise_nxt[l]       = rise_r[l];
            byte_nxt[l*8 +: 8] = byte_r[l*8 +: 8];
            if (dqsTS[l] && !dqsCS[l]) begin
                hi_nxt[l] = 1'b1;
            end else if (!dqsTS[l] && dqsCS[l]) begin
                hi_nxt[l] = 1'b0;
            end
            if (hi_nxt[l] != hi_r[l] && !ownDrv) begin
                stb_nxt[l]        = 1'b1;
                rise_nxt[l]       = hi_nxt[l];
                byte_nxt[l*8 +: 8] = dqS[l*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rs1_r  <= '0;
            rs2_r  <= '0;
            oeHist_r <= '0;
            hi_r   <= '0;
            stb_r  <= '0;
            rise_r <= '0;
            byte_r <= '0;
        end else if (ce) begin
            rs1_r  <= {link.dq, link.dqsT, link.dqsC};
            rs2_r  <= rs1_r;
            oeHist_r <= {oeHist_r[0], oe_r};
            hi_r   <= hi_nxt;
            stb_r  <= stb_nxt;
            rise_r <= rise_nxt;
            byte_r <= byte_nxt;
        end
    end

    assign link.ckT     = ckT_r;
    assign link.ckC     = !ckT_r;
    assign link.cke     = cke_r;
    assign link.csN     = csN_r;
    assign link.ca      = ca_r;
    assign link.dm      = dm_r;
    assign link.hostDq  = dq_r;
    assign link.hostDqsT = {LN{dqsT_r}};
    assign link.hostDqsC = {LN{!dqsT_r}};
    assign link.hostOe  = {LN{oe_r}};
    assign cmdReady     = cmdReady_r;
    assign wrReady      = wrReady_r;
    assign rdStb        = stb_r;
    assign rdRise       = rise_r;
    assign rdData       = byte_r;
endmodule

// ---- core/lpc_device.sv ----
// Memory device end: command/address capture and data byte lanes
`timescale 1ns/1ps
`include "lpc_defines.svh"
module lpc_device
    import lpc_pkg::*;
#(
    parameter int DQW = `LPC_DQW
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               ce,
    lpc_link_if.device              link,
    output logic                    cmdValid,
    output lpc_cmd_s                cmdWord,
    output logic                    ckeLive,
    output logic                    pdEnter,
    output logic                    pdExit,
    input  wire logic               rdValid,
    output logic                    rdReady,
    input  wire logic [2*DQW-1:0]   rdData,
    output logic [DQW/8-1:0]        wrStb,
    output logic [DQW/8-1:0]        wrRise,
    output logic [DQW/8-1:0]        wrByteEn,
    output logic [DQW-1:0]          wrData
);
    localparam int LN = DQW / `LPC_BYTE_W;
    localparam int SW = 4 + `LPC_CA_W + LN + DQW + 2 * LN;

    if (DQW != 16 && DQW != 32) begin : g_chk
        $error("lpc_device: DQW must be 16 or 32");
    end

    // Every pin passes two flops; only the second stage is read
    logic [SW-1:0]        s1_r, s1_nxt, s2_r;
    logic                 ckTS, ckCS, ckeS, csNS;
    logic [`LPC_CA_W-1:0] caS;
    logic [LN-1:0]        dmS, dqsTS, dqsCS;
    logic [DQW-1:0]       dqS;

    always_comb begin
        s1_nxt = {link.ckT, link.ckC, link.cke, link.csN, link.ca,
                  link.dm, link.dq, link.dqsT, link.dqsC};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else if (ce) begin
            s1_r <= s1_nxt;
            s2_r <= s1_r;
        end
    end

    assign {ckTS, ckCS, ckeS, csNS, caS, dmS, dqS, dqsTS, dqsCS} = s2_r;

    // Clock edges, clock enable and command assembly
    logic     ckHi_r, ckHi_nxt, ckPos, ckNeg;
    logic     ckeLive_r, ckeLive_nxt;
    logic     pdEnter_r, pdEnter_nxt, pdExit_r, pdExit_nxt;
    logic     pend_r, pend_nxt;
    lpc_cmd_s hold_r, hold_nxt, cmd_r, cmd_nxt;
    logic     cmdValid_r, cmdValid_nxt;

    always_comb begin
        // A crossing counts only against the opposite previous level
        ckPos    = ckTS && !ckCS && !ckHi_r;
        ckNeg    = !ckTS && ckCS && ckHi_r;
        ckHi_nxt = ckPos ? 1'b1 : (ckNeg ? 1'b0 : ckHi_r);
        ckeLive_nxt  = ckeLive_r;
        pdEnter_nxt  = 1'b0;
        pdExit_nxt   = 1'b0;
        pend_nxt     = pend_r;
        hold_nxt     = hold_r;
        cmd_nxt      = cmd_r;
        cmdValid_nxt = 1'b0;
        if (ckPos) begin
            ckeLive_nxt     = ckeS;
            pdEnter_nxt     = ckeLive_r && !ckeS;
            pdExit_nxt      = !ckeLive_r && ckeS;
            hold_nxt.ckePrev = ckeLive_r;
            hold_nxt.ckeNow  = ckeS;
            hold_nxt.csN     = csNS;
            hold_nxt.caRise  = caS;
            hold_nxt.caFall  = '0;
            // With clock enable low on both edges the clocks are stopped
            pend_nxt = ckeLive_r || ckeS;
        end else if (ckNeg && pend_r) begin
            cmd_nxt        = hold_r;
            cmd_nxt.caFall = caS;
            cmdValid_nxt   = 1'b1;
            pend_nxt       = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ckHi_r     <= 1'b0;
            ckeLive_r  <= `LPC_CKE_RST;
            pdEnter_r  <= 1'b0;
            pdExit_r   <= 1'b0;
            pend_r     <= 1'b0;
            hold_r     <= '0;
            cmd_r      <= '0;
            cmdValid_r <= 1'b0;
        end else if (ce) begin
            ckHi_r     <= ckHi_nxt;
            ckeLive_r  <= ckeLive_nxt;
            pdEnter_r  <= pdEnter_nxt;
            pdExit_r   <= pdExit_nxt;
            pend_r     <= pend_nxt;
            hold_r     <= hold_nxt;
            cmd_r      <= cmd_nxt;
            cmdValid_r <= cmdValid_nxt;
        end
    end

    // Read burst: two beats, strobe edges move with the data
    lpc_rd_e          rdSt_r, rdSt_nxt;
    logic             rdReady_r, rdReady_nxt;
    logic [DQW-1:0]   b0_r, b0_nxt, b1_r, b1_nxt, dq_r, dq_nxt;
    logic             dqsT_r, dqsT_nxt, oe_r, oe_nxt;

    always_comb begin
        rdSt_nxt = rdSt_r;
        b0_nxt   = b0_r;
        b1_nxt   = b1_r;
        dq_nxt   = dq_r;
        dqsT_nxt = dqsT_r;
        oe_nxt   = oe_r;
        unique case (rdSt_r)
            RD_IDLE: if (rdValid && rdReady_r) begin
                b0_nxt   = rdData[DQW-1:0];
                b1_nxt   = rdData[2*DQW-1:DQW];
                rdSt_nxt = RD_WAIT;
            end
            RD_WAIT: if (ckPos && ckeS) begin
                dq_nxt   = b0_r;
                dqsT_nxt = 1'b1;
                oe_nxt   = 1'b1;
                rdSt_nxt = RD_BEAT0;
            end
            RD_BEAT0: if (ckNeg) begin
                dq_nxt   = b1_r;
                dqsT_nxt = 1'b0;
                rdSt_nxt = RD_BEAT1;
            end
            RD_BEAT1: if (ckPos) begin
                oe_nxt   = 1'b0;
                rdSt_nxt = RD_IDLE;
            end
        endcase
        // No read is accepted while clock enable is low
        rdReady_nxt = (rdSt_nxt == RD_IDLE) && ckeLive_nxt;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdSt_r    <= RD_IDLE;
            rdReady_r <= 1'b0;
            b0_r      <= '0;
            b1_r      <= '0;
            dq_r      <= '0;
            dqsT_r    <= `LPC_DQS_T_IDLE;
            oe_r      <= 1'b0;
        end else if (ce) begin
            rdSt_r    <= rdSt_nxt;
            rdReady_r <= rdReady_nxt;
            b0_r      <= b0_nxt;
            b1_r      <= b1_nxt;
            dq_r      <= dq_nxt;
            dqsT_r    <= dqsT_nxt;
            oe_r      <= oe_nxt;
        end
    end

    // Write lanes: each strobe pair and mask bit owns one byte
    logic [LN-1:0]  hi_r, hi_nxt, stb_r, stb_nxt, rise_r, rise_nxt;
    logic [LN-1:0]  en_r, en_nxt;
    logic [DQW-1:0] byte_r, byte_nxt;
    logic [1:0]     oeHist_r;
    logic           ownDrv;

    // Own strobe edges still sit in the synchroniser after oe drops
    assign ownDrv = oe_r || (oeHist_r != 2'b00);

    genvar l;
    for (l = 0; l < LN; l++) begin : g_wr
        always_comb begin
            hi_nxt[l]          = hi_r[l];
            stb_nxt[l]         = 1'b0;
            rise_nxt[l]        = rise_r[l];
            en_nxt[l]          = en_r[l];
            byte_nxt[l*8 +: 8] = byte_r[l*8 +: 8];
            if (dqsTS[l] && !dqsCS[l]) begin
                hi_nxt[l] = 1'b1;
            end else if (!dqsTS[l] && dqsCS[l]) begin
                hi_nxt[l] = 1'b0;
            end
            // Own read strobe is not taken as write timing
            if (hi_nxt[l] != hi_r[l] && !ownDrv && ckeLive_r) begin
                stb_nxt[l]         = 1'b1;
                rise_nxt[l]        = hi_nxt[l];
                en_nxt[l]          = !dmS[l];
                byte_nxt[l*8 +: 8] = dmS[l] ? 8'h00 : dqS[l*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_r   <= '0;
            oeHist_r <= '0;
            stb_r  <= '0;
            rise_r <= '0;
            en_r   <= '0;
            byte_r <= '0;
        end else if (ce) begin
            hi_r   <= hi_nxt;
            oeHist_r <= {oeHist_r[0], oe_r};
            stb_r  <= stb_nxt;
            rise_r <= rise_nxt;
            en_r   <= en_nxt;
            byte_r <= byte_nxt;
        end
    end

    assign link.devDq   = dq_r;
    assign link.devDqsT = {LN{dqsT_r}};
    assign link.devDqsC = {LN{!dqsT_r}};
    assign link.devOe   = {LN{oe_r}};
    assign cmdValid     = cmdValid_r;
    assign cmdWord      = cmd_r;
    assign ckeLive      = ckeLive_r;
    assign pdEnter      = pdEnter_r;
    assign pdExit       = pdExit_r;
    assign rdReady      = rdReady_r;
    assign wrStb        = stb_r;
    assign wrRise       = rise_r;
    assign wrByteEn     = en_r;
    assign wrData       = byte_r;
endmodule

// ---- tb/lpc_link_props.sv ----
// Concurrent checks on the pin bundle between both ends
`timescale 1ns/1ps
module lpc_link_props #(
    parameter int DQW     = 32,
    parameter int CK_HALF = 4,
    parameter int LN      = DQW / 8
) (
    input wire logic           clk,
    input wire logic           rstn,
    input wire logic           ckT,
    input wire logic           ckC,
    input wire logic           cke,
    input wire logic           csN,
    input wire logic [9:0]     ca,
    input wire logic [DQW-1:0] dq,
    input wire logic [LN-1:0]  dqsT,
    input wire logic [LN-1:0]  dqsC,
    input wire logic [LN-1:0]  hostOe,
    input wire logic [LN-1:0]  devOe
);
    logic [7:0] cnt_r, cnt_nxt;
    logic       seen_r, armed_r, armed_nxt;
    // Armed only after the first edge: the wait from reset is not a half
    always_comb begin
        cnt_nxt   = (ckT != seen_r) ? 8'h00 : cnt_r + 8'h01;
        armed_nxt = armed_r | (ckT != seen_r);
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r   <= 8'h00;
            seen_r  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            seen_r  <= ckT;
            armed_r <= armed_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_CK_HALF: assert property (armed_r && ckT != seen_r
        |-> cnt_r == 8'(CK_HALF - 1)) else $error("bad half period");
    AST_CK_DIFF: assert property (ckC == ~ckT)
        else $error("clock pair not complementary");
    AST_SDR_EDGE: assert property (
        $changed(csN) || $changed(cke) |-> $fell(ckT))
        else $error("select or enable moved off the fall");
    // Each address half must stand across its edge
    AST_CA_EDGE: assert property ($changed(ckT)
        |-> $stable(ca) ##1 $stable(ca))
        else $error("address moved at a clock edge");
    AST_ONE_DRV: assert property ((hostOe & devOe) == '0)
        else $error("both ends drive data");
    AST_DQS_DIFF: assert property (dqsC == ~dqsT)
        else $error("strobe pair not complementary");
    // Mid-eye strobe: data must not move at or just after its edge
    AST_WR_CENTRE: assert property (
        hostOe != '0 && $changed(dqsT) |-> $stable(dq) ##1 $stable(dq))
        else $error("write data moved at strobe edge");
    AST_RD_ALIGN: assert property (
        devOe != '0 && $stable(devOe) && $changed(dq) |-> $changed(dqsT))
        else $error("read data moved without strobe edge");
    AST_RD_START: assert property (
        $rose(devOe[0]) |-> devOe == '1 && dqsT == '1)
        else $error("read burst opened badly");
endmodule

// ---- tb/lpddr3_pin_capture_lanes_tb.sv ----
// Bench joining host and device ends over the pin bundle
`timescale 1ns/1ps
`define CHK_EQ(g, e) begin n_compared++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); \
    end end
module lpddr3_pin_capture_lanes_tb
    import lpc_pkg::*;
;
    localparam int DQW = 32;
    localparam int CKH = 4;
    logic        clk = 1'b0, rstn = 1'b0, ckePrev = 1'b0, hCmdV = 1'b0;
    logic        hWrV = 1'b0, dRdV = 1'b0, hCke = 1'b0, hCsN = 1'b1;
    logic        hCmdR, hWrR, dCmdV, dCkeLive, dPdEnter, dPdExit, dRdR;
    int          err_total = 0, n_compared = 0, nEnter = 0, nExit = 0;
    int          nRd = 0, nWr = 0;
    logic [9:0]  hRise = '0, hFall = '0;
    logic [7:0]  hWrMask = '0;
    logic [63:0] hWrData = '0, dRdData = '0;
    logic [3:0]  hRdStb, hRdRise, dWrStb, dWrRise, dWrEn;
    logic [31:0] hRdData, dWrData;
    lpc_cmd_s    dCmdWord;
    logic [21:0] cmdTbl [6] = '{22'h2F_FC00, 22'h3A_A955, 22'h20_0600,
                                22'h04_8F21, 22'h03_C00F, 22'h27_0C3C};

    lpc_link_if #(.DQW(DQW)) lnk ();
    lpc_host #(.DQW(DQW), .CK_HALF(CKH)) i_lpc_host (
        .clk, .rstn, .ce(1'b1), .link(lnk), .cmdValid(hCmdV),
        .cmdReady(hCmdR), .cmdCke(hCke), .cmdCsN(hCsN), .cmdCaRise(hRise),
        .cmdCaFall(hFall), .wrValid(hWrV), .wrReady(hWrR),
        .wrData(hWrData), .wrMask(hWrMask), .rdStb(hRdStb),
        .rdRise(hRdRise), .rdData(hRdData));
    lpc_device #(.DQW(DQW)) i_lpc_device (
        .clk, .rstn, .ce(1'b1), .link(lnk), .cmdValid(dCmdV),
        .cmdWord(dCmdWord), .ckeLive(dCkeLive), .pdEnter(dPdEnter),
        .pdExit(dPdExit), .rdValid(dRdV), .rdReady(dRdR), .rdData(dRdData),
        .wrStb(dWrStb), .wrRise(dWrRise), .wrByteEn(dWrEn),
        .wrData(dWrData));
    lpc_link_props #(.DQW(DQW), .CK_HALF(CKH)) i_props (
        .clk, .rstn, .ckT(lnk.ckT), .ckC(lnk.ckC), .cke(lnk.cke),
        .csN(lnk.csN), .ca(lnk.ca), .dq(lnk.dq), .dqsT(lnk.dqsT),
        .dqsC(lnk.dqsC), .hostOe(lnk.hostOe), .devOe(lnk.devOe));

    always #10 clk = ~clk;
    always @(negedge clk) begin
        nEnter += int'(dPdEnter === 1'b1);
        nExit  += int'(dPdExit === 1'b1);
        nRd    += int'(hRdStb !== 4'h0);
        nWr    += int'(dWrStb !== 4'h0);
    end

    task automatic take(input int k);
        int i;
        i = 0;
        while ((k == 0 ? hCmdR : k == 1 ? hWrR : dRdR) !== 1'b1 && i < 60)
        begin
            @(negedge clk);
            i++;
        end
        @(negedge clk);
        {hCmdV, hWrV, dRdV} = 3'h0;
    endtask

    task automatic sendCmd(input logic [21:0] c);
        int i;
        {hCke, hCsN, hRise, hFall} = c;
        hCmdV = 1'b1;
        take(0);
        // Skip past the report of the period before ours
        repeat (7) @(negedge clk);
        i = 0;
        while (dCmdV !== 1'b1 && i < 12) begin
            @(negedge clk);
            i++;
        end
        if (c[21] | ckePrev) begin
            `CHK_EQ(dCmdWord, {ckePrev, c})
        end else begin
            `CHK_EQ(dCmdV, 1'b0)
        end
        ckePrev = c[21];
        `CHK_EQ(dCkeLive, ckePrev)
    endtask

    task automatic beat(input bit wr, input logic rise,
                        input logic [31:0] ed, input logic [3:0] en);
        int i;
        logic [43:0] g;
        i = 0;
        while ((wr ? dWrStb : hRdStb) === 4'h0 && i < 40) begin
            @(negedge clk);
            i++;
        end
        g = wr ? {dWrStb, dWrRise, dWrEn, dWrData}
               : {hRdStb, hRdRise, 4'h0, hRdData};
        `CHK_EQ(g, {4'hF, {4{rise}}, en, ed})
        @(negedge clk);
    endtask

    task automatic testCommands;
        for (int k = 0; k < 6; k++) sendCmd(cmdTbl[k]);
        `CHK_EQ(nEnter, 1)
        `CHK_EQ(nExit, 2)
        $display("command test done");
    endtask

    task automatic testWrites;
        {hWrData, hWrMask, hWrV} = {64'h8877_6655_4433_2211, 8'h00, 1'b1};
        take(1);
        beat(1'b1, 1'b1, 32'h4433_2211, 4'hF);
        beat(1'b1, 1'b0, 32'h8877_6655, 4'hF);
        {hWrData, hWrMask, hWrV} = {64'hF0E1_D2C3_B4A5_9687, 8'h69, 1'b1};
        take(1);
        beat(1'b1, 1'b1, 32'h00A5_9600, 4'h6);
        beat(1'b1, 1'b0, 32'hF000_00C3, 4'h9);
        // The host must not take its own write strobe as read timing
        `CHK_EQ(nRd, 0)
        $display("write test done");
    endtask

    task automatic testReads;
        {dRdData, dRdV} = {64'h0123_4567_89AB_CDEF, 1'b1};
        take(2);
        beat(1'b0, 1'b1, 32'h89AB_CDEF, 4'h0);
        beat(1'b0, 1'b0, 32'h0123_4567, 4'h0);
        `CHK_EQ(nRd, 2)
        `CHK_EQ(nWr, 4)
        $display("read test done");
    endtask

    task automatic summarize;
        $display("compared %0d, mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        testCommands();
        testWrites();
        testReads();
        summarize();
    end

    // Whole run needs well under a thousand clocks
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
